/* File: inc/adcsq_pkg.sv */
// package for the converter sequencer and its register file
`default_nettype none
package adcsq_pkg;
	// register byte addresses on the axi4-lite bus
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h4;
	localparam logic [3:0] ADDR_RES_LO = 4'h8;
	localparam logic [3:0] ADDR_RES_HI = 4'hC;
	localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
	localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h14;
	localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h18;
	// control a field positions
	localparam int BIT_START = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_ENABLE = 5;
	localparam int BIT_ALIGN = 4;
	// reset values
	localparam logic [7:0] RST_CTRL_A = 8'h00;
	localparam logic [7:0] RST_CTRL_B = 8'h00;
	// result width and conversion length in converter clock periods
	localparam int RES_W = 12;
	localparam int CONV_CLOCKS = 16;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// codes of the input source, channel and reference fields
	localparam logic [2:0] SRC_BANDGAP = 3'h1;
	localparam logic [2:0] SRC_AMP_A = 3'h2;
	localparam logic [2:0] SRC_AMP_B = 3'h3;
	localparam logic [2:0] SRC_NEG_SUPPLY = 3'h4;
	localparam logic [3:0] CH_RESERVED = 4'h7;
	localparam logic [3:0] CH_LAST = 4'h9;
	localparam logic [1:0] REF_INTERNAL = 2'h1;

	// analog front-end steering bundle
	typedef struct packed {
		logic [9:0] channel_onehot; // external pin connected, bit n for input n
		logic bandgap_sel;
		logic amp_a_sel;
		logic amp_b_sel;
		logic neg_supply_sel;
		logic ref_internal;
		logic powered;
	} adcsq_mux_s;

	typedef enum logic [1:0] {IDLE, CONVERT} adcsq_state_e;
endpackage
`default_nettype wire

/* File: hw/adcsq_top.sv */
// converter sequencer, register file and axi4-lite slave
// Operation
// - result is 12 bits unsigned from one shared multiplexed converter
// - start bit written high then low begins a conversion
// - busy flag set on start, cleared when conversion ends
// - busy flag is read only; writes to it ignored
// - enable bit low switches converter off, high enables it
// - disabled converter leaves result registers unchanged
// - alignment 0: high byte D11..D4, low byte upper nibble D3..D0
// - alignment 1: high byte low nibble D11..D8, low byte D7..D0
// - unused result bits read as zero
// - channel code n selects input n; code 0111 reserved
// - channel codes 1010 to 1111 connect no pin
// - source 001 bandgap, 010/011 amplifiers, 100 negative supply, else external
// - reference code 01 internal supply, other codes external pin
// - converter clock is system clock divided by two to the select value
// - pin used as analog input loses digital function and pull-high
// - conversion end sets an interrupt flag; busy may be polled instead
`default_nettype none
module adcsq_top #(
	parameter int CONV_CLOCKS = adcsq_pkg::CONV_CLOCKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// axi4-lite slave
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter core
	input wire logic [11:0] core_result,
	output logic conv_clock,
	output logic sample_strobe,
	output adcsq_pkg::adcsq_mux_s mux,
	// pin function override, one bit per external input
	input wire logic [9:0] pin_analog_cfg,
	output logic [9:0] pin_digital_off,
	output logic [9:0] pin_pullup_off,
	// interrupt
	output logic irq
);
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic [11:0] result;
	logic busy;
	logic irq_status;
	logic irq_enable;
	logic start_seen;
	logic [7:0] div_cnt;
	logic [7:0] div_mask;
	logic conv_tick;
	logic [7:0] clk_cnt;
	adcsq_pkg::adcsq_state_e state;
	logic aw_held;
	logic w_held;
	logic [4:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_do;
	logic rd_do;
	logic done;
	logic start_req;
	logic [7:0] next_ctrl_a;
	logic [7:0] res_lo;
	logic [7:0] res_hi;
	logic [31:0] next_rdata;
	logic wr_hit_a;

	// write channels are taken independently, then committed once both are held
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_do = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_do = s_axi_arvalid && s_axi_arready;

	// address and data capture
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (wr_do)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (wr_do)
				w_held <= 1'b0;
		end
	end

	// write response: unmapped and read-only offsets answer slverr
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= adcsq_pkg::RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr)
				{1'b0, adcsq_pkg::ADDR_CTRL_A}, {1'b0, adcsq_pkg::ADDR_CTRL_B},
				adcsq_pkg::ADDR_IRQ_ENABLE, adcsq_pkg::ADDR_IRQ_CLEAR:
					s_axi_bresp <= adcsq_pkg::RESP_OKAY;
				default:
					s_axi_bresp <= adcsq_pkg::RESP_SLVERR;
			endcase
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	assign wr_hit_a = wr_do && aw_addr == {1'b0, adcsq_pkg::ADDR_CTRL_A} && w_strb[0];

	// busy bit keeps the hardware value whatever software writes
	always_comb
	begin
		next_ctrl_a = w_data[7:0];
		next_ctrl_a[adcsq_pkg::BIT_BUSY] = 1'b0;
	end

	// start arms on the high write and fires on the following low write
	assign start_req = wr_hit_a && start_seen && !next_ctrl_a[adcsq_pkg::BIT_START];

	// control registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_a <= adcsq_pkg::RST_CTRL_A;
			ctrl_b <= adcsq_pkg::RST_CTRL_B;
			start_seen <= 1'b0;
		end
		else
		begin
			if (wr_hit_a)
			begin
				ctrl_a <= next_ctrl_a;
				start_seen <= next_ctrl_a[adcsq_pkg::BIT_START];
			end
			if (wr_do && aw_addr == {1'b0, adcsq_pkg::ADDR_CTRL_B} && w_strb[0])
				ctrl_b <= w_data[7:0];
		end
	end

	// divider: a count held at zero while idle; mask picks divide by 2**select
	assign div_mask = 8'(({1'b0, 8'h01} << ctrl_b[2:0]) - 9'h001);
	assign conv_tick = (div_cnt & div_mask) == div_mask;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			div_cnt <= 8'h00;
		else if (state == adcsq_pkg::IDLE)
			div_cnt <= 8'h00;
		else
			div_cnt <= div_cnt + 8'h01;
	end
	// clock output is the top bit of the divided count, full rate passes through
	assign conv_clock = (ctrl_b[2:0] == 3'h0) ? clk : div_cnt[ctrl_b[2:0] - 3'h1];

	// sequencer: counts converter clocks while converting
	// a tick that meets a switch-off is an abort: no strobe, no result, no flag
	assign done = state == adcsq_pkg::CONVERT && conv_tick && ctrl_a[adcsq_pkg::BIT_ENABLE]
		&& clk_cnt == 8'(CONV_CLOCKS - 1);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= adcsq_pkg::IDLE;
			busy <= 1'b0;
			clk_cnt <= 8'h00;
		end
		else
		begin
			case (state)
				adcsq_pkg::IDLE:
					if (start_req && ctrl_a[adcsq_pkg::BIT_ENABLE])
					begin
						state <= adcsq_pkg::CONVERT;
						busy <= 1'b1;
						clk_cnt <= 8'h00;
					end
				adcsq_pkg::CONVERT:
					if (!ctrl_a[adcsq_pkg::BIT_ENABLE])
					begin
						// switching off aborts; the result is left alone
						state <= adcsq_pkg::IDLE;
						busy <= 1'b0;
					end
					else if (done)
					begin
						state <= adcsq_pkg::IDLE;
						busy <= 1'b0;
					end
					else if (conv_tick)
						clk_cnt <= clk_cnt + 8'h01;
				default:
					state <= adcsq_pkg::IDLE;
			endcase
		end
	end
	assign sample_strobe = done;

	// result capture only on a completed, enabled conversion
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			result <= 12'h000;
		else if (done && ctrl_a[adcsq_pkg::BIT_ENABLE])
			result <= core_result;
	end

	// alignment of the 12-bit value into two bytes
	always_comb
	begin
		if (ctrl_a[adcsq_pkg::BIT_ALIGN])
		begin
			res_hi = {4'h0, result[11:8]};
			res_lo = result[7:0];
		end
		else
		begin
			res_hi = result[11:4];
			res_lo = {result[3:0], 4'h0};
		end
	end

	// input multiplexer steering; the core only sees what is selected here
	always_comb
	begin
		mux = '0;
		mux.powered = ctrl_a[adcsq_pkg::BIT_ENABLE];
		mux.ref_internal = ctrl_b[4:3] == adcsq_pkg::REF_INTERNAL;
		case (ctrl_b[7:5])
			adcsq_pkg::SRC_BANDGAP: mux.bandgap_sel = 1'b1;
			adcsq_pkg::SRC_AMP_A: mux.amp_a_sel = 1'b1;
			adcsq_pkg::SRC_AMP_B: mux.amp_b_sel = 1'b1;
			adcsq_pkg::SRC_NEG_SUPPLY: mux.neg_supply_sel = 1'b1;
			default: mux.bandgap_sel = 1'b0;
		endcase
		// external switch closes even with an internal source, so software
		// must use a floating code there
		if (ctrl_a[3:0] <= adcsq_pkg::CH_LAST && ctrl_a[3:0] != adcsq_pkg::CH_RESERVED)
			mux.channel_onehot = 10'(10'h001 << ctrl_a[3:0]);
		else
			mux.channel_onehot = 10'h000;
	end

	// analog pins drop their digital role and pull-high
	assign pin_digital_off = pin_analog_cfg;
	assign pin_pullup_off = pin_analog_cfg;

	// completion interrupt; a new completion beats a same-cycle clear
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_status <= 1'b0;
			irq_enable <= 1'b0;
		end
		else
		begin
			if (done)
				irq_status <= 1'b1;
			else if (wr_do && aw_addr == adcsq_pkg::ADDR_IRQ_CLEAR && w_strb[0] && w_data[0])
				irq_status <= 1'b0;
			if (wr_do && aw_addr == adcsq_pkg::ADDR_IRQ_ENABLE && w_strb[0])
				irq_enable <= w_data[0];
		end
	end
	assign irq = irq_status && irq_enable;

	// read decode
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (s_axi_araddr)
			{1'b0, adcsq_pkg::ADDR_CTRL_A}:
			begin
				next_rdata[7:0] = ctrl_a;
				next_rdata[adcsq_pkg::BIT_BUSY] = busy;
			end
			{1'b0, adcsq_pkg::ADDR_CTRL_B}: next_rdata[7:0] = ctrl_b;
			{1'b0, adcsq_pkg::ADDR_RES_LO}: next_rdata[7:0] = res_lo;
			{1'b0, adcsq_pkg::ADDR_RES_HI}: next_rdata[7:0] = res_hi;
			adcsq_pkg::ADDR_IRQ_STATUS: next_rdata[0] = irq_status;
			adcsq_pkg::ADDR_IRQ_ENABLE: next_rdata[0] = irq_enable;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// read data channel
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= adcsq_pkg::RESP_OKAY;
		end
		else if (rd_do)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			case (s_axi_araddr)
				{1'b0, adcsq_pkg::ADDR_CTRL_A}, {1'b0, adcsq_pkg::ADDR_CTRL_B},
				{1'b0, adcsq_pkg::ADDR_RES_LO}, {1'b0, adcsq_pkg::ADDR_RES_HI},
				adcsq_pkg::ADDR_IRQ_STATUS, adcsq_pkg::ADDR_IRQ_ENABLE:
					s_axi_rresp <= adcsq_pkg::RESP_OKAY;
				default:
					s_axi_rresp <= adcsq_pkg::RESP_SLVERR;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// checks
	chk_start_sets_busy: assert property (@(posedge clk) disable iff (!nrst)
		start_req && ctrl_a[adcsq_pkg::BIT_ENABLE] && state == adcsq_pkg::IDLE |=> busy)
		else $error("busy not set after start");
	chk_done_clears_busy: assert property (@(posedge clk) disable iff (!nrst)
		done && ctrl_a[adcsq_pkg::BIT_ENABLE] |=> !busy && result == $past(core_result))
		else $error("completion did not clear busy and load result");
	chk_busy_write_ignored: assert property (@(posedge clk) disable iff (!nrst)
		!busy && state == adcsq_pkg::IDLE && !start_req |=> !busy)
		else $error("busy rose without start");
	chk_off_no_start: assert property (@(posedge clk) disable iff (!nrst)
		!ctrl_a[adcsq_pkg::BIT_ENABLE] |=> state == adcsq_pkg::IDLE)
		else $error("converter runs while disabled");
	chk_off_holds_result: assert property (@(posedge clk) disable iff (!nrst)
		!ctrl_a[adcsq_pkg::BIT_ENABLE] |=> $stable(result))
		else $error("result changed while disabled");
	chk_align_zero: assert property (@(posedge clk) disable iff (!nrst)
		(ctrl_a[adcsq_pkg::BIT_ALIGN] ? res_hi[7:4] : res_lo[3:0]) == 4'h0)
		else $error("unused result bits not zero");
	chk_chan_float: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_a[3:0] > adcsq_pkg::CH_LAST || ctrl_a[3:0] == adcsq_pkg::CH_RESERVED
		|-> mux.channel_onehot == 10'h000)
		else $error("pin connected on floating code");
	chk_done_irq: assert property (@(posedge clk) disable iff (!nrst)
		done |=> irq_status ##0 (irq == irq_enable))
		else $error("completion flag missing");
endmodule // adcsq_top
`default_nettype wire

/* File: tb/adcsq_core_model.sv */
// converter core stand-in: answers each selected external input and the bandgap with its own code
`default_nettype none
module adcsq_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// steering from the sequencer
	input wire adcsq_pkg::adcsq_mux_s mux,
	// result to the sequencer
	output logic [11:0] core_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] drift;
	// a floating input reads as noise, never as the last held value
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			drift <= 12'h000;
		else
			drift <= ~drift + 12'h3A7;
	end
	// one shared converter, each external input and the bandgap give a distinct 12-bit code
	always_comb
	begin
		core_result = drift;
		for (int n = 0; n < 10; n++)
			if (mux.channel_onehot[n])
				core_result = 12'hC35 + 12'h111 * n[11:0];
		if (mux.bandgap_sel)
			core_result = 12'h4D2;
	end
endmodule // adcsq_core_model
`default_nettype wire

/* File: tb/test_adcsq_top.sv */
// self-checking bench for the converter sequencer and its registers
`default_nettype none
`define CHK(nm, ex, got) \
	begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("Error %s expected %0h seen %0h", nm, ex, got); end end
module test_adcsq_top;
	timeunit 1ns;
	timeprecision 1ps;
	// short conversions keep the slowest divider run brief
	localparam int C = 2;
	localparam logic [1:0] OK = adcsq_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = adcsq_pkg::RESP_SLVERR;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic [4:0] araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [9:0] pin_cfg = 10'h2B5;
	logic awready, wready, bvalid, arready, rvalid, conv_clock, sample_strobe, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] core_result;
	logic [9:0] dig_off, pu_off;
	adcsq_pkg::adcsq_mux_s mux;
	int mismatches = 0;
	int n_checks = 0;
	int n_strobe = 0;
	int n_cc = 0;
	int cyc = 0;

	always #2.5 clk = ~clk;
	// cycle and conversion-end counters used to time conversions
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (sample_strobe)
			n_strobe <= n_strobe + 1;
		// only meaningful while the divider select is non-zero
		if (conv_clock)
			n_cc <= n_cc + 1;
	end

	adcsq_top #(.CONV_CLOCKS(C)) u_dut (
		.clk(clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.core_result(core_result), .conv_clock(conv_clock), .sample_strobe(sample_strobe),
		.mux(mux), .pin_analog_cfg(pin_cfg), .pin_digital_off(dig_off),
		.pin_pullup_off(pu_off), .irq(irq)
	);
	adcsq_core_model u_core (.clk(clk), .nrst(nrst), .mux(mux), .core_result(core_result));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask

	task automatic axi_rd(input logic [4:0] a, input logic [31:0] ex, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		`CHK("rdata", ex, rdata)
		`CHK("rresp", er, rresp)
	endtask

	// watchdog: the whole sequence needs a few thousand cycles
	initial
	begin
		#250000;
		mismatches++;
		report_and_stop();
	end

	initial
	begin
		int t0, s0, c0;
		logic [11:0] v;
		logic [3:0] ch;
		logic [7:0] hi, lo;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		axi_rd(5'h00, 32'h0, OK);
		axi_rd(5'h04, 32'h0, OK);
		axi_rd(5'h10, 32'h0, OK);
		`CHK("irq", 1'b0, irq)
		repeat (2)
		begin
			@(posedge clk);
			pin_cfg <= ~pin_cfg;
			@(posedge clk);
			#1;
			`CHK("digital_off", pin_cfg, dig_off)
			`CHK("pullup_off", pin_cfg, pu_off)
		end
		axi_rd(5'h1C, 32'h0, ERR);
		axi_wr(5'h08, 32'hFF, ERR);
		$display("test reset_map done");
		axi_wr(5'h00, 32'h4F, OK);
		axi_rd(5'h00, 32'h0F, OK);
		`CHK("powered", 1'b0, mux.powered)
		for (int c = 0; c < 16; c++)
		begin
			axi_wr(5'h00, 32'h20 | 32'(c), OK);
			`CHK("powered", 1'b1, mux.powered)
			if (c != 7)
				`CHK("onehot", (c < 10) ? 10'h001 << c : 10'h000, mux.channel_onehot)
		end
		for (int s = 0; s < 8; s++)
		begin
			axi_wr(5'h04, 32'(s) << 5, OK);
			// internal sources get a floating channel code
			axi_wr(5'h00, (s inside {[1:4]}) ? 32'h2F : 32'h23, OK);
			`CHK("src", {(s inside {[1:4]}) ? 10'h000 : 10'h008, s == 1, s == 2, s == 3, s == 4, 2'b01}, mux)
		end
		for (int r = 0; r < 4; r++)
		begin
			axi_wr(5'h04, 32'(r) << 3, OK); // reference pin never given its input role
			`CHK("ref", r == 1, mux.ref_internal)
		end
		axi_rd(5'h04, 32'h18, OK);
		$display("test decode done");
		for (int k = 0; k < 8; k++)
		begin
			ch = (k == 7) ? 4'h8 : k[3:0];
			v = 12'hC35 + 12'h111 * ch;
			axi_wr(5'h04, 32'(k), OK);
			axi_wr(5'h00, {24'h0, 3'b101, k[0], ch}, OK);
			s0 = n_strobe;
			t0 = cyc;
			c0 = n_cc;
			axi_wr(5'h00, {24'h0, 3'b001, k[0], ch}, OK);
			if (k > 2)
				axi_rd(5'h00, {24'h0, 3'b011, k[0], ch}, OK);
			while (n_strobe == s0) @(posedge clk);
			`CHK("conv_len", 1'b1, cyc - t0 >= (C << k) && cyc - t0 <= (C << k) + 6)
			if (k > 0)
				`CHK("conv_clock", C << (k - 1), n_cc - c0)
			axi_rd(5'h00, {24'h0, 3'b001, k[0], ch}, OK);
			hi = k[0] ? {4'h0, v[11:8]} : v[11:4];
			lo = k[0] ? v[7:0] : {v[3:0], 4'h0};
			axi_rd(5'h0C, {24'h0, hi}, OK);
			axi_rd(5'h08, {24'h0, lo}, OK);
			axi_rd(5'h10, 32'h1, OK);
			if (k == 0)
			begin
				`CHK("irq", 1'b0, irq)
				axi_wr(5'h14, 32'h1, OK);
			end
			`CHK("irq", 1'b1, irq)
			axi_wr(5'h18, 32'h1, OK);
			`CHK("irq", 1'b0, irq)
		end
		$display("test conversions done");
		// slowest divider: a wrongly started conversion would end inside the wait
		s0 = n_strobe;
		axi_wr(5'h00, 32'hB8, OK);
		repeat (300) @(posedge clk);
		`CHK("strobes", s0, n_strobe)
		axi_wr(5'h00, 32'h38, OK);
		axi_wr(5'h00, 32'h18, OK);
		axi_wr(5'h00, 32'h98, OK);
		axi_wr(5'h00, 32'h18, OK);
		repeat (300) @(posedge clk);
		`CHK("strobes", s0, n_strobe)
		axi_rd(5'h0C, {24'h0, hi}, OK);
		axi_rd(5'h08, {24'h0, lo}, OK);
		axi_rd(5'h10, 32'h0, OK);
		$display("test disable done");
		report_and_stop();
	end
endmodule // test_adcsq_top
`undef CHK
`default_nettype wire
